// *** frame_offset_counter.sv ***
// classifier constants and the byte offset counter used by the filter
`timescale 1ns/10ps
`default_nettype none

package discovery_filter_pkg;
    // byte offsets within a received frame
    localparam logic [10:0] OFF_DST_MAC = 11'h000;
    localparam logic [10:0] OFF_ETYPE = 11'h00C;
    localparam logic [10:0] OFF_IP_HDR = 11'h00E;
    localparam logic [10:0] OFF_IP6_NEXT = 11'h014;
    localparam logic [10:0] OFF_IP4_PROTO = 11'h017;
    localparam logic [10:0] OFF_IP4_DST = 11'h01E;
    localparam logic [10:0] OFF_UDP6_DPORT = 11'h038;
    localparam logic [10:0] UDP_DPORT_SKIP = 11'h002;
    localparam logic [10:0] OFF_MAX = 11'h7FF;
    localparam logic [10:0] OFF_ONE = 11'h001;
    // field lengths in bytes
    localparam logic [3:0] LEN_MAC = 4'h6;
    localparam logic [3:0] LEN_PREFIX = 4'h5;
    localparam logic [3:0] LEN_ETYPE = 4'h2;
    localparam logic [3:0] LEN_IP4 = 4'h4;
    localparam logic [3:0] LEN_PORT = 4'h2;
    localparam logic [3:0] LEN_ONE = 4'h1;
    // enable bit positions in the filter setting
    localparam int EN_LLDP = 6;
    localparam int EN_MDNS4 = 7;
    localparam int EN_MDNS6 = 8;
    localparam int SETTING_W = 9;
    // match values
    localparam logic [63:0] LLDP_PREFIX = 64'h0000_0001_80C2_0000;
    localparam logic [7:0] LLDP_LAST_A = 8'h00;
    localparam logic [7:0] LLDP_LAST_B = 8'h03;
    localparam logic [7:0] LLDP_LAST_C = 8'h0E;
    localparam logic [63:0] ETYPE_LLDP = 64'h0000_0000_0000_88CC;
    localparam logic [63:0] MAC_MDNS4 = 64'h0000_0100_5E00_00FB;
    localparam logic [63:0] ETYPE_IPV4 = 64'h0000_0000_0000_0800;
    localparam logic [63:0] IP4_MDNS = 64'h0000_0000_E000_00FB;
    localparam logic [63:0] MAC_MDNS6 = 64'h0000_3333_0000_00FB;
    localparam logic [63:0] ETYPE_IPV6 = 64'h0000_0000_0000_86DD;
    localparam logic [63:0] PROTO_UDP = 64'h0000_0000_0000_0011;
    localparam logic [63:0] PORT_MDNS = 64'h0000_0000_0000_14E9;
    localparam logic [3:0] IHL_MIN = 4'h5;

    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_frame = 2'h2
    } frame_state_t;
endpackage

module frame_offset_counter (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // receive strobes
    input wire logic byte_valid,
    input wire logic byte_sof,
    // offset of the byte now on the stream
    output logic [10:0] cur_offset
);
    logic [10:0] count;
    logic [10:0] next_count;

    // saturates so very long frames do not wrap into the header fields
    always_comb begin
        cur_offset = byte_sof ? discovery_filter_pkg::OFF_DST_MAC : count;
        next_count = count;
        if (byte_valid && cur_offset != discovery_filter_pkg::OFF_MAX) begin
            next_count = cur_offset + discovery_filter_pkg::OFF_ONE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= discovery_filter_pkg::OFF_DST_MAC;
        end else begin
            count <= next_count;
        end
    end
endmodule

`default_nettype wire

// *** discovery_packet_filter.sv ***
// discovery frame and multicast dns classifier on the receive path
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1 - each type enable set forwards matching frames; clear filters them out
// RULE2 - bit 6 of the filter setting enables link-layer discovery frames
// RULE3 - discovery destination MAC is 01:80:C2:00:00 plus 00, 03 or 0E
// RULE4 - discovery frames also need Ethertype 0x88CC
// RULE5 - discovery enable support is optional, chosen by a parameter
// RULE6 - discovery copies are only observed; the port stream is untouched
// RULE7 - controller should prefer a multicast address filter for single addresses
// RULE8 - mdns over ipv4 needs all field conditions together
// RULE9 - mdns ipv4 destination MAC is 01:00:5E:00:00:FB
// RULE10 - mdns ipv4 Ethertype is 0x0800
// RULE11 - mdns ipv4 destination address is 224.0.0.251
// RULE12 - mdns ipv4 protocol number is 17, UDP
// RULE13 - mdns ipv4 UDP destination port is 5353
// RULE14 - bit 8 enables mdns over ipv6 with the same encoding
// RULE15 - bit 7 enables mdns over ipv4
// RULE16 - mdns ipv6 needs group MAC, Ethertype 0x86DD, UDP and port 5353
module discovery_packet_filter #(
    parameter bit LLDP_SUPPORTED = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // received frame from the network port
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    // filter setting from the command logic
    input wire logic [8:0] filter_setting,
    // unchanged copy toward the port's own processing
    output logic port_valid,
    output logic [7:0] port_data,
    output logic port_sof,
    output logic port_eof,
    // per-frame verdict toward the management_controller path
    output logic verdict_valid,
    output logic verdict_forward,
    output logic match_lldp,
    output logic match_mdns4,
    output logic match_mdns6
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic in_field(input logic [10:0] off, input logic [10:0] base, input logic [3:0] len);
        return (off >= base) && (off < base + {7'h00, len});
    endfunction

    // byte idx of a big-endian field len bytes long held in the low bits of value
    function automatic logic [7:0] field_byte(input logic [63:0] value, input logic [3:0] len,
                                              input logic [10:0] off, input logic [10:0] base);
        logic [3:0] idx;
        logic [6:0] sh;
        idx = 4'(off - base);
        sh = {len - discovery_filter_pkg::LEN_ONE - idx, 3'h0};
        return 8'(value >> sh);
    endfunction

    function automatic logic field_ok(input logic [7:0] data, input logic [63:0] value, input logic [3:0] len,
                                      input logic [10:0] off, input logic [10:0] base);
        return !in_field(off, base, len) || (data == field_byte(value, len, off, base));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [10:0] off;
    discovery_filter_pkg::frame_state_t state, next_state;
    logic lldp_ok, v4_ok, v6_ok, next_lldp_ok, next_v4_ok, next_v6_ok;
    logic lldp_done, v4_done, v6_done, next_lldp_done, next_v4_done, next_v6_done;
    logic [3:0] ihl, next_ihl;
    logic [10:0] udp4_base;
    logic take;
    logic next_verdict_valid, next_verdict_forward;
    logic next_match_lldp, next_match_mdns4, next_match_mdns6;
    logic lldp_en;

    frame_offset_counter u_offset (
        .clk(clk),
        .nrst(nrst),
        .byte_valid(rx_valid),
        .byte_sof(rx_sof),
        .cur_offset(off)
    );

    // udp header starts after a variable length ipv4 header
    assign udp4_base = discovery_filter_pkg::OFF_IP_HDR + {5'h00, ihl, 2'h0} + discovery_filter_pkg::UDP_DPORT_SKIP;
    assign take = rx_valid && (rx_sof || state == discovery_filter_pkg::st_frame);
    assign lldp_en = LLDP_SUPPORTED && filter_setting[discovery_filter_pkg::EN_LLDP]; // RULE2 RULE5

    always_comb begin
        next_state = state;
        next_lldp_ok = lldp_ok;
        next_v4_ok = v4_ok;
        next_v6_ok = v6_ok;
        next_lldp_done = lldp_done;
        next_v4_done = v4_done;
        next_v6_done = v6_done;
        next_ihl = ihl;
        next_verdict_valid = 1'b0;
        next_verdict_forward = verdict_forward;
        next_match_lldp = match_lldp;
        next_match_mdns4 = match_mdns4;
        next_match_mdns6 = match_mdns6;
        if (take) begin
            if (rx_sof) begin
                next_lldp_ok = 1'b1;
                next_v4_ok = 1'b1;
                next_v6_ok = 1'b1;
                next_lldp_done = 1'b0;
                next_v4_done = 1'b0;
                next_v6_done = 1'b0;
                next_ihl = discovery_filter_pkg::IHL_MIN;
            end
            // discovery group address and ethertype
            next_lldp_ok = next_lldp_ok
                && field_ok(rx_data, discovery_filter_pkg::LLDP_PREFIX, discovery_filter_pkg::LEN_PREFIX,
                            off, discovery_filter_pkg::OFF_DST_MAC) // RULE3
                && field_ok(rx_data, discovery_filter_pkg::ETYPE_LLDP, discovery_filter_pkg::LEN_ETYPE,
                            off, discovery_filter_pkg::OFF_ETYPE); // RULE4
            if (off == discovery_filter_pkg::OFF_DST_MAC + 11'(discovery_filter_pkg::LEN_PREFIX)
                && rx_data != discovery_filter_pkg::LLDP_LAST_A && rx_data != discovery_filter_pkg::LLDP_LAST_B
                && rx_data != discovery_filter_pkg::LLDP_LAST_C) begin
                next_lldp_ok = 1'b0; // RULE3
            end
            // every ipv4 condition must hold; any miss clears the flag for the frame
            next_v4_ok = next_v4_ok
                && field_ok(rx_data, discovery_filter_pkg::MAC_MDNS4, discovery_filter_pkg::LEN_MAC,
                            off, discovery_filter_pkg::OFF_DST_MAC) // RULE9
                && field_ok(rx_data, discovery_filter_pkg::ETYPE_IPV4, discovery_filter_pkg::LEN_ETYPE,
                            off, discovery_filter_pkg::OFF_ETYPE) // RULE10
                && field_ok(rx_data, discovery_filter_pkg::PROTO_UDP, discovery_filter_pkg::LEN_ONE,
                            off, discovery_filter_pkg::OFF_IP4_PROTO) // RULE12
                && field_ok(rx_data, discovery_filter_pkg::IP4_MDNS, discovery_filter_pkg::LEN_IP4,
                            off, discovery_filter_pkg::OFF_IP4_DST) // RULE11
                && field_ok(rx_data, discovery_filter_pkg::PORT_MDNS, discovery_filter_pkg::LEN_PORT,
                            off, udp4_base); // RULE13 RULE8
            if (off == discovery_filter_pkg::OFF_IP_HDR) begin
                next_ihl = rx_data[3:0];
                if (rx_data[3:0] < discovery_filter_pkg::IHL_MIN) begin
                    next_v4_ok = 1'b0;
                end
            end
            next_v6_ok = next_v6_ok
                && field_ok(rx_data, discovery_filter_pkg::MAC_MDNS6, discovery_filter_pkg::LEN_MAC,
                            off, discovery_filter_pkg::OFF_DST_MAC)
                && field_ok(rx_data, discovery_filter_pkg::ETYPE_IPV6, discovery_filter_pkg::LEN_ETYPE,
                            off, discovery_filter_pkg::OFF_ETYPE)
                && field_ok(rx_data, discovery_filter_pkg::PROTO_UDP, discovery_filter_pkg::LEN_ONE,
                            off, discovery_filter_pkg::OFF_IP6_NEXT)
                && field_ok(rx_data, discovery_filter_pkg::PORT_MDNS, discovery_filter_pkg::LEN_PORT,
                            off, discovery_filter_pkg::OFF_UDP6_DPORT); // RULE16
            // a frame that ends before its last checked byte never matches
            if (off == discovery_filter_pkg::OFF_ETYPE + discovery_filter_pkg::OFF_ONE) begin
                next_lldp_done = 1'b1;
            end
            if (off == udp4_base + discovery_filter_pkg::OFF_ONE && off > discovery_filter_pkg::OFF_IP4_DST) begin
                next_v4_done = 1'b1; // RULE8
            end
            if (off == discovery_filter_pkg::OFF_UDP6_DPORT + discovery_filter_pkg::OFF_ONE) begin
                next_v6_done = 1'b1;
            end
            next_state = discovery_filter_pkg::st_frame;
            if (rx_eof) begin
                next_state = discovery_filter_pkg::st_idle;
                next_verdict_valid = 1'b1;
                next_match_lldp = next_lldp_ok && next_lldp_done;
                next_match_mdns4 = next_v4_ok && next_v4_done;
                next_match_mdns6 = next_v6_ok && next_v6_done;
                next_verdict_forward = (next_match_lldp && lldp_en) // RULE1 RULE6
                    || (next_match_mdns4 && filter_setting[discovery_filter_pkg::EN_MDNS4]) // RULE15
                    || (next_match_mdns6 && filter_setting[discovery_filter_pkg::EN_MDNS6]); // RULE14
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= discovery_filter_pkg::st_idle;
            lldp_ok <= 1'b0;
            v4_ok <= 1'b0;
            v6_ok <= 1'b0;
            lldp_done <= 1'b0;
            v4_done <= 1'b0;
            v6_done <= 1'b0;
            ihl <= discovery_filter_pkg::IHL_MIN;
            verdict_valid <= 1'b0;
            verdict_forward <= 1'b0;
            match_lldp <= 1'b0;
            match_mdns4 <= 1'b0;
            match_mdns6 <= 1'b0;
        end else begin
            case (next_state)
                discovery_filter_pkg::st_idle: state <= discovery_filter_pkg::st_idle;
                discovery_filter_pkg::st_frame: state <= discovery_filter_pkg::st_frame;
                default: state <= discovery_filter_pkg::st_idle;
            endcase
            lldp_ok <= next_lldp_ok;
            v4_ok <= next_v4_ok;
            v6_ok <= next_v6_ok;
            lldp_done <= next_lldp_done;
            v4_done <= next_v4_done;
            v6_done <= next_v6_done;
            ihl <= next_ihl;
            verdict_valid <= next_verdict_valid;
            verdict_forward <= next_verdict_forward;
            match_lldp <= next_match_lldp;
            match_mdns4 <= next_match_mdns4;
            match_mdns6 <= next_match_mdns6;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port path sees every frame one cycle later, whatever the verdict
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_valid <= 1'b0;
            port_data <= 8'h00;
            port_sof <= 1'b0;
            port_eof <= 1'b0;
        end else begin
            port_valid <= rx_valid; // RULE6
            port_data <= rx_data;
            port_sof <= rx_sof;
            port_eof <= rx_eof;
        end
    end
endmodule

`default_nettype wire

// *** discovery_packet_filter_props.sv ***
// assertion checker for the discovery packet filter ports
`timescale 1ns/10ps
`default_nettype none

module discovery_packet_filter_props #(
    parameter bit LLDP_SUPPORTED = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // receive stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic [8:0] filter_setting,
    // port copy
    input wire logic port_valid,
    input wire logic [7:0] port_data,
    input wire logic port_sof,
    input wire logic port_eof,
    // verdict
    input wire logic verdict_valid,
    input wire logic verdict_forward,
    input wire logic match_lldp,
    input wire logic match_mdns4,
    input wire logic match_mdns6
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    property p_port_data;
        rx_valid |=> port_valid && port_data == $past(rx_data) && port_sof == $past(rx_sof)
            && port_eof == $past(rx_eof);
    endproperty
    a_port_data: assert property (p_port_data) else $error("port copy differs from received byte");
    property p_port_idle;
        !rx_valid |=> !port_valid;
    endproperty
    a_port_idle: assert property (p_port_idle) else $error("port copy valid without a byte");
    property p_verdict_cause;
        verdict_valid |-> $past(rx_valid) && $past(rx_eof);
    endproperty
    a_verdict_cause: assert property (p_verdict_cause) else $error("verdict without end byte");
    property p_single_frame;
        rx_valid && rx_sof && rx_eof |=> verdict_valid;
    endproperty
    a_single_frame: assert property (p_single_frame) else $error("no verdict after one byte frame");
    property p_fwd_cause;
        verdict_valid && verdict_forward |-> (match_lldp && $past(filter_setting[6]) && LLDP_SUPPORTED)
            || (match_mdns4 && $past(filter_setting[7])) || (match_mdns6 && $past(filter_setting[8]));
    endproperty
    a_fwd_cause: assert property (p_fwd_cause) else $error("forward without enabled match");
    property p_lldp_en;
        verdict_valid && match_lldp && $past(filter_setting[6]) && LLDP_SUPPORTED |-> verdict_forward;
    endproperty
    a_lldp_en: assert property (p_lldp_en) else $error("discovery match not forwarded");
    property p_mdns4_en;
        verdict_valid && match_mdns4 && $past(filter_setting[7]) |-> verdict_forward;
    endproperty
    a_mdns4_en: assert property (p_mdns4_en) else $error("mdns ipv4 match not forwarded");
    property p_mdns6_en;
        verdict_valid && match_mdns6 && $past(filter_setting[8]) |-> verdict_forward;
    endproperty
    a_mdns6_en: assert property (p_mdns6_en) else $error("mdns ipv6 match not forwarded");
    property p_hold;
        !verdict_valid |-> $stable(verdict_forward) && $stable(match_lldp) && $stable(match_mdns4)
            && $stable(match_mdns6);
    endproperty
    a_hold: assert property (p_hold) else $error("verdict changed between frames");
    property p_exclusive;
        verdict_valid |-> !(match_lldp && (match_mdns4 || match_mdns6)) && !(match_mdns4 && match_mdns6);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("two types matched one frame");
endmodule

bind discovery_packet_filter discovery_packet_filter_props #(.LLDP_SUPPORTED(LLDP_SUPPORTED))
    discovery_packet_filter_props_i (.clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .filter_setting(filter_setting), .port_valid(port_valid),
    .port_data(port_data), .port_sof(port_sof), .port_eof(port_eof), .verdict_valid(verdict_valid),
    .verdict_forward(verdict_forward), .match_lldp(match_lldp), .match_mdns4(match_mdns4),
    .match_mdns6(match_mdns6));
`default_nettype wire

// *** mgmt_ctrl_model.sv ***
// management controller model counting forwarded frame copies
`timescale 1ns/10ps
`default_nettype none

module mgmt_ctrl_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // verdicts from the filter
    input wire logic verdict_valid,
    input wire logic verdict_forward,
    // copies taken so far
    output logic [15:0] copies
);
    logic [15:0] next_copies;

    // broad filter only; a single address of interest would use a mac filter instead
    always_comb begin
        next_copies = copies;
        if (verdict_valid && verdict_forward) begin
            next_copies = copies + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            copies <= 16'h0000;
        end else begin
            copies <= next_copies;
        end
    end
endmodule
`default_nettype wire

// *** discovery_packet_filter_tb_top.sv ***
// self-checking testbench for the discovery packet filter
`timescale 1ns/10ps
`default_nettype none

module discovery_packet_filter_tb_top;
    logic clk, nrst, rx_valid, rx_sof, rx_eof, port_valid, port_sof, port_eof;
    logic verdict_valid, verdict_forward, match_lldp, match_mdns4, match_mdns6;
    logic nl_forward, nl_match_lldp;
    logic [7:0] rx_data, port_data;
    logic [8:0] filter_setting;
    logic [15:0] copies, exp_copies;
    logic [7:0] frm[$];
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    discovery_packet_filter discovery_packet_filter_i (.clk(clk), .nrst(nrst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .filter_setting(filter_setting),
        .port_valid(port_valid), .port_data(port_data), .port_sof(port_sof), .port_eof(port_eof),
        .verdict_valid(verdict_valid), .verdict_forward(verdict_forward), .match_lldp(match_lldp),
        .match_mdns4(match_mdns4), .match_mdns6(match_mdns6));
    // second copy built without the optional discovery enable
    discovery_packet_filter #(.LLDP_SUPPORTED(1'b0)) discovery_packet_filter_nolldp_i (.clk(clk), .nrst(nrst),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof), .filter_setting(filter_setting),
        .port_valid(), .port_data(), .port_sof(), .port_eof(), .verdict_valid(), .verdict_forward(nl_forward),
        .match_lldp(nl_match_lldp), .match_mdns4(), .match_mdns6());
    mgmt_ctrl_model mgmt_ctrl_model_i (.clk(clk), .nrst(nrst), .verdict_valid(verdict_valid),
        .verdict_forward(verdict_forward), .copies(copies));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // generous ceiling, the frames need about 1250 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic mk_base(input logic [47:0] mac, input logic [15:0] et);
        frm.delete();
        for (int i = 0; i < 64; i++) frm.push_back(8'h00);
        for (int i = 0; i < 6; i++) frm[i] = mac[47 - 8 * i -: 8];
        frm[12] = et[15:8];
        frm[13] = et[7:0];
    endtask

    // bad selects one broken field; 5 is clean, 6 is clean with a longer ip header
    task automatic mk4(input int bad);
        logic [3:0] ihl;
        int p;
        ihl = (bad == 6) ? 4'h6 : 4'h5;
        p = 16 + 4 * int'(ihl);
        mk_base((bad == 0) ? 48'h01005E0000FC : 48'h01005E0000FB, (bad == 1) ? 16'h0806 : 16'h0800);
        frm[14] = {4'h4, ihl};
        frm[23] = (bad == 2) ? 8'h06 : 8'h11;
        frm[30] = 8'hE0;
        frm[33] = (bad == 3) ? 8'hFA : 8'hFB;
        frm[p] = 8'h14;
        frm[p + 1] = (bad == 4) ? 8'hEA : 8'hE9;
    endtask

    // pre junk bytes open a frame that the real start of frame restarts
    task automatic send(input logic [8:0] fs, input int pre, input logic e_fwd, e_l, e_4, e_6);
        filter_setting = fs;
        for (int i = 0; i < pre; i++) begin
            @(negedge clk);
            {rx_valid, rx_sof, rx_eof, rx_data} = {1'b1, i == 0, 1'b0, 8'h01};
        end
        foreach (frm[i]) begin
            if (i == 21) begin
                @(negedge clk);
                rx_valid = 1'b0;
            end
            @(negedge clk);
            {rx_valid, rx_sof, rx_eof, rx_data} = {1'b1, i == 0, i == frm.size() - 1, frm[i]};
        end
        @(negedge clk);
        {rx_valid, rx_sof, rx_eof} = 3'h0;
        chk_bit("verdict_valid", 1'b1, verdict_valid);
        chk_bit("verdict_forward", e_fwd, verdict_forward);
        chk_bit("match_lldp", e_l, match_lldp);
        chk_bit("match_mdns4", e_4, match_mdns4);
        chk_bit("match_mdns6", e_6, match_mdns6);
        chk_bit("port_valid", 1'b1, port_valid);
        chk_bit("port_eof", 1'b1, port_eof);
        chk_cnt("port_data", {8'h00, frm[frm.size() - 1]}, {8'h00, port_data});
        if (e_fwd) exp_copies = exp_copies + 16'h0001;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_lldp;
        logic [7:0] last[3] = '{8'h00, 8'h03, 8'h0E};
        foreach (last[i]) begin
            mk_base({40'h0180C20000, last[i]}, 16'h88CC);
            send(9'h040, 0, 1'b1, 1'b1, 1'b0, 1'b0);
            chk_bit("nolldp_match", 1'b1, nl_match_lldp);
            chk_bit("nolldp_forward", 1'b0, nl_forward);
        end
        mk_base(48'h0180C2000001, 16'h88CC);
        send(9'h1C0, 0, 1'b0, 1'b0, 1'b0, 1'b0);
        mk_base(48'h0180C200000E, 16'h88CD);
        send(9'h1C0, 0, 1'b0, 1'b0, 1'b0, 1'b0);
        mk_base(48'h0180C2000003, 16'h88CC);
        send(9'h180, 0, 1'b0, 1'b1, 1'b0, 1'b0);
        send(9'h040, 3, 1'b1, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_mdns4;
        for (int b = 0; b < 7; b++) begin
            mk4(b);
            send(9'h080, 0, b > 4, 1'b0, b > 4, 1'b0);
        end
        mk4(5);
        send(9'h140, 0, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_mdns6;
        mk_base(48'h3333000000FB, 16'h86DD);
        frm[20] = 8'h11;
        frm[56] = 8'h14;
        frm[57] = 8'hE9;
        send(9'h100, 0, 1'b1, 1'b0, 1'b0, 1'b1);
        send(9'h0C0, 0, 1'b0, 1'b0, 1'b0, 1'b1);
        frm[20] = 8'h06;
        send(9'h1C0, 0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic t_short;
        frm = '{8'h01};
        send(9'h1C0, 0, 1'b0, 1'b0, 1'b0, 1'b0);
        mk4(5);
        frm = frm[0:35];
        send(9'h1C0, 0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    initial begin
        {nrst, rx_valid, rx_sof, rx_eof, rx_data, filter_setting} = '0;
        exp_copies = 16'h0000;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        t_lldp();
        t_mdns4();
        t_mdns6();
        t_short();
        @(negedge clk);
        chk_cnt("copies", exp_copies, copies);
        test_done();
    end
endmodule
`default_nettype wire
